// *** core/vrs_pkg.sv ***
// Package for the core-regulator start-up and protection sequencer.
// Assumes a 50 MHz system clock; analog comparators sit outside.
package vrs_pkg;
   // ==========================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_PS = 20000;
   localparam int unsigned INIT_DELAY_NS = 1360000; // 1.36 ms
   localparam int unsigned BOOT_HOLD_NS = 85000;    // Fixed hold at boot level
   localparam int unsigned VID_CHECK_NS = 500;      // Least code check time
   localparam int unsigned READY_DELAY_NS = 85000;  // 85 us
   localparam int unsigned INIT_DELAY_CYC = INIT_DELAY_NS * 1000 / CLK_PERIOD_PS;
   localparam int unsigned BOOT_HOLD_CYC = BOOT_HOLD_NS * 1000 / CLK_PERIOD_PS;
   localparam int unsigned VID_CHECK_CYC = (VID_CHECK_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int unsigned READY_DELAY_CYC = READY_DELAY_NS * 1000 / CLK_PERIOD_PS;
   localparam int unsigned HICCUP_SW_CYC = 4096;
   localparam int unsigned OC_CONSEC_CYC = 8;
   // ==========================================
   // DAC codes in 6.25 mV units
   localparam int unsigned DAC_W = 9;
   localparam logic [8:0] DAC_ZERO = 9'h000;
   localparam logic [8:0] DAC_STEP = 9'h001;       // 6.25 mV
   localparam logic [8:0] DAC_BOOT = 9'h0B0;       // 1.1 V
   localparam logic [8:0] DAC_OV_FIXED = 9'h0CC;   // 1.275 V
   localparam logic [8:0] DAC_OV_MARGIN = 9'h01C;  // 175 mV
   localparam int unsigned CNT_W = 17;
   // ==========================================
   // Sequencer states, Gray coded along the start path
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_DELAY = 3'b001,
      ST_RAMP1 = 3'b011,
      ST_HOLD = 3'b010,
      ST_RAMP2 = 3'b110,
      ST_RUN = 3'b111,
      ST_LATCH = 3'b101,
      ST_HICCUP = 3'b100
   } vrs_state_type;
   // PWM pin drive mode
   typedef enum logic [1:0] {
      PWM_HIZ = 2'b00,
      PWM_LOW = 2'b01,
      PWM_RUN = 2'b10
   } vrs_pwm_type;
endpackage : vrs_pkg

// *** core/vrs_sync.sv ***
// Two-stage synchroniser bank for comparator results.
// Assumes inputs are asynchronous levels from analog comparators.
`timescale 1ns/10ps
module vrs_sync #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================
   // Stages
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : vrs_sync

// *** core/vrs_sequencer.sv ***
// Start-up, ready and fault sequencer for a multiphase core regulator.
// Assumes comparator outputs arrive asynchronously and that the driver
// stage resolves the PWM pin level from output enable and output value.
`timescale 1ns/10ps
// Summary of operation
// - PWM pins high impedance in shutdown
// - Start only after supply POR good
// - Power-rail enable gates start
// - All three start conditions together
// - Wait initial delay before ramp
// - First ramp rises to boot level
// - One DAC step per oscillator period
// - Hold boot, then check code 500ns
// - Valid code: ramp to the target code
// - OFF code shuts down until cycled
// - Ready released after start plus delay
// - Ready low on faults and disable
// - Undervoltage drops ready, recovers at 60%
// - Overvoltage fixed trip before second ramp
// - Valid code: trip at target plus margin
// - Overvoltage drives PWM low, then high-Z
// - Repeat low drive while overvoltage recurs
// - Overvoltage latch cleared only by cycling
// - Averaged current trip is immediate
// - Channel trip after eight consecutive cycles
// - Overcurrent: high-Z for 4096 cycles
// - Retry soft-start while still enabled
// - Driver enable high from ramp start
// - Overcurrent drops driver enable
// - Overvoltage keeps driver enable until discharged
module vrs_sequencer
   import vrs_pkg::*;
#(
   parameter int unsigned PHASES = 6,
   parameter int unsigned INIT_DELAY = INIT_DELAY_CYC,
   parameter int unsigned BOOT_HOLD = BOOT_HOLD_CYC,
   parameter int unsigned READY_DELAY = READY_DELAY_CYC,
   parameter int unsigned HICCUP = HICCUP_SW_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Supply and enable comparators (asynchronous)
   input wire logic por_good_in,
   input wire logic power_rail_enable_in,
   input wire logic term_rail_enable_in,
   // Output monitors (asynchronous)
   input wire logic under_trip_in,
   input wire logic under_recover_in,
   input wire logic over_trip_in,
   input wire logic diff_output_sense_low_in,
   input wire logic averaged_channel_current_over_in,
   input wire logic [PHASES-1:0] channel_current_over_in,
   // Timebases (synchronous one-cycle ticks)
   input wire logic switch_tick_in,
   input wire logic ss_tick_in,
   // Voltage ID
   input wire logic [7:0] voltage_id_code,
   input wire logic vid_off_in,
   input wire logic [8:0] vid_target_in,
   // Analog side
   output logic [8:0] dac_code_out,
   output logic [8:0] overvoltage_guard,
   // Driver stage
   output logic [PHASES-1:0] pwm_en_out,
   output logic [PHASES-1:0] pwm_oe_out,
   output logic driver_enable_out,
   // Open-drain ready
   output logic regulator_ready_out_o,
   output logic regulator_ready_out_oe
);
   // ==========================================
   // Synchronised comparators
   localparam int unsigned NSYNC = 8 + PHASES;
   logic [NSYNC-1:0] sync_raw;
   logic [NSYNC-1:0] sync_val;
   logic por_s, pwr_s, vtt_s, uv_s, uvr_s, ov_s, dlow_s, iavg_s;
   logic [PHASES-1:0] ich_s;

   // Slow comparators would glitch the state machine without this
   vrs_sync #(.WIDTH(NSYNC)) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(sync_raw),
      .sync_out(sync_val)
   );

   // Packing of comparator levels
   assign sync_raw = {channel_current_over_in, averaged_channel_current_over_in,
      diff_output_sense_low_in, over_trip_in, under_recover_in, under_trip_in,
      term_rail_enable_in, power_rail_enable_in, por_good_in};
   assign {ich_s, iavg_s, dlow_s, ov_s, uvr_s, uv_s, vtt_s, pwr_s, por_s} = sync_val;

   // ==========================================
   // State
   vrs_state_type state_q;
   vrs_pwm_type pwm_mode_q;
   logic [CNT_W-1:0] cnt_q;
   logic [3:0] oc_run_q [PHASES];
   logic [PHASES-1:0] oc_ch_hit;
   logic vid_valid_q;
   logic off_lock_q;
   logic ov_seen_q;
   logic ready_pend_q;
   logic uv_q;
   logic enabled;
   logic oc_trip;
   logic [8:0] ramp_goal;

   // Start needs all three conditions at once
   assign enabled = por_s & pwr_s & vtt_s;
   // Averaged trip is immediate, channel trip needs a full run
   assign oc_trip = iavg_s | (|oc_ch_hit);
   assign ramp_goal = (state_q == ST_RAMP2) ? vid_target_in : DAC_BOOT;

   // ==========================================
   // Per-channel consecutive overcurrent counters
   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_chan
         always_ff @(posedge sys_clk) begin
            if (sys_rst || state_q == ST_OFF) begin
               oc_run_q[g] <= 4'h0;
            end else if (switch_tick_in) begin
               // Any clean cycle restarts the run
               oc_run_q[g] <= ich_s[g] ? ((oc_run_q[g] == 4'(OC_CONSEC_CYC)) ?
                  oc_run_q[g] : oc_run_q[g] + 4'h1) : 4'h0;
            end
         end
         assign oc_ch_hit[g] = (oc_run_q[g] == 4'(OC_CONSEC_CYC));
      end
   endgenerate

   // ==========================================
   // Main sequencer
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
         cnt_q <= '0;
         dac_code_out <= DAC_ZERO;
      end else if (!enabled) begin
         state_q <= ST_OFF;
         cnt_q <= '0;
         dac_code_out <= DAC_ZERO;
      end else if (ov_s || ov_seen_q) begin
         state_q <= ST_LATCH;
         cnt_q <= '0;
      end else if (oc_trip && state_q != ST_OFF && state_q != ST_HICCUP) begin
         state_q <= ST_HICCUP;
         cnt_q <= '0;
         dac_code_out <= DAC_ZERO;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               if (!off_lock_q) begin
                  state_q <= ST_DELAY;
                  cnt_q <= '0;
               end
            end
            ST_DELAY: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CNT_W'(INIT_DELAY - 1)) begin
                  state_q <= ST_RAMP1;
                  cnt_q <= '0;
               end
            end
            ST_RAMP1, ST_RAMP2: begin
               // Step only on the oscillator tick
               if (dac_code_out == ramp_goal) begin
                  state_q <= (state_q == ST_RAMP1) ? ST_HOLD : ST_RUN;
                  cnt_q <= '0;
               end else if (ss_tick_in) begin
                  dac_code_out <= (dac_code_out < ramp_goal) ? dac_code_out + DAC_STEP :
                     dac_code_out - DAC_STEP;
               end
            end
            ST_HOLD: begin
               cnt_q <= cnt_q + 1'b1;
               // Code sampled only after hold plus check window
               if (cnt_q == CNT_W'(BOOT_HOLD + VID_CHECK_CYC - 1)) begin
                  cnt_q <= '0;
                  state_q <= vid_off_in ? ST_OFF : ST_RAMP2;
               end
            end
            ST_RUN: begin
               dac_code_out <= vid_target_in;
               // Saturating ready-delay count; cnt_q is free once the ramps are done
               if (cnt_q != CNT_W'(READY_DELAY - 1)) begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_HICCUP: begin
               cnt_q <= switch_tick_in ? cnt_q + 1'b1 : cnt_q;
               if (switch_tick_in && cnt_q == CNT_W'(HICCUP - 1)) begin
                  state_q <= ST_DELAY;
                  cnt_q <= '0;
               end
            end
            ST_LATCH: begin
               cnt_q <= '0;
            end
            default: begin
               state_q <= ST_OFF;
            end
         endcase
      end
   end

   // ==========================================
   // OFF-code lock and overvoltage latch, cleared only by disable
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !enabled) begin
         off_lock_q <= 1'b0;
         ov_seen_q <= 1'b0;
      end else begin
         if (state_q == ST_HOLD && cnt_q == CNT_W'(BOOT_HOLD + VID_CHECK_CYC - 1)
            && vid_off_in) begin
            off_lock_q <= 1'b1;
         end
         if (ov_s) begin
            ov_seen_q <= 1'b1;
         end
      end
   end

   // ==========================================
   // Valid code flag selects the overvoltage trip level
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !enabled || state_q == ST_OFF || state_q == ST_HICCUP) begin
         vid_valid_q <= 1'b0;
      end else if (state_q == ST_RAMP2) begin
         vid_valid_q <= 1'b1;
      end
   end

   // Trip level output; works regardless of enable
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         overvoltage_guard <= DAC_OV_FIXED;
      end else if (vid_valid_q) begin
         overvoltage_guard <= vid_target_in + DAC_OV_MARGIN;
      end else begin
         overvoltage_guard <= DAC_OV_FIXED;
      end
   end

   // ==========================================
   // PWM pin mode; overvoltage acts even with the regulator off
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pwm_mode_q <= PWM_HIZ;
      end else if (ov_s) begin
         pwm_mode_q <= PWM_LOW;
      end else if (pwm_mode_q == PWM_LOW) begin
         pwm_mode_q <= dlow_s ? PWM_HIZ : PWM_LOW;
      end else if (state_q == ST_RAMP1 || state_q == ST_RAMP2 || state_q == ST_HOLD
         || state_q == ST_RUN) begin
         pwm_mode_q <= oc_trip ? PWM_HIZ : PWM_RUN;
      end else begin
         pwm_mode_q <= PWM_HIZ;
      end
   end

   // Pin drive: low mode drives zero, run hands control to modulators
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pwm_oe_out <= '0;
         pwm_en_out <= '0;
      end else begin
         pwm_oe_out <= (pwm_mode_q == PWM_HIZ) ? '0 : '1;
         pwm_en_out <= (pwm_mode_q == PWM_RUN) ? '1 : '0;
      end
   end

   // ==========================================
   // Driver enable; stays up through overvoltage discharge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         driver_enable_out <= 1'b0;
      end else if (oc_trip && pwm_mode_q != PWM_LOW) begin
         driver_enable_out <= 1'b0;
      end else if (pwm_mode_q == PWM_LOW || ov_s) begin
         // Lower switches keep draining the rail until the sense reads low
         driver_enable_out <= ov_s || !dlow_s;
      end else if (state_q == ST_RAMP1 || state_q == ST_HOLD || state_q == ST_RAMP2
         || state_q == ST_RUN) begin
         driver_enable_out <= 1'b1;
      end else begin
         driver_enable_out <= 1'b0;
      end
   end

   // ==========================================
   // Undervoltage hysteresis: trip at 50%, release at 60%
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_q != ST_RUN) begin
         uv_q <= 1'b0;
      end else if (uv_s) begin
         uv_q <= 1'b1;
      end else if (uvr_s) begin
         uv_q <= 1'b0;
      end
   end

   // Ready delay after a completed start
   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_q != ST_RUN) begin
         ready_pend_q <= 1'b0;
      end else if (cnt_q == CNT_W'(READY_DELAY - 1)) begin
         ready_pend_q <= 1'b1;
      end
   end

   // Ready counter reuses cnt_q only while running
   // Open-drain ready: pulled low unless every condition holds
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         regulator_ready_out_o <= 1'b0;
         regulator_ready_out_oe <= 1'b1;
      end else begin
         regulator_ready_out_o <= 1'b0;
         regulator_ready_out_oe <= !(ready_pend_q && state_q == ST_RUN && !uv_q
            && !uv_s && !ov_s && enabled);
      end
   end

   // ==========================================
   // Assertions
   a_shutdown_hiz: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_OFF && !ov_s && pwm_mode_q == PWM_HIZ |=> pwm_oe_out == '0)
      else $error("pwm driven in shutdown");
   a_start_needs_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_OFF && !enabled |=> state_q == ST_OFF)
      else $error("left shutdown while disabled");
   a_delay_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(state_q == ST_DELAY) |-> !(state_q == ST_RAMP1)[*8])
      else $error("initial delay too short");
   a_ramp_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
      state_q == ST_RAMP1 && !ss_tick_in && enabled && !oc_trip && !ov_s && !ov_seen_q
      |=> $stable(dac_code_out))
      else $error("dac moved without tick");
   a_ov_low_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ov_s |=> pwm_mode_q == PWM_LOW ##1 pwm_oe_out == '1 && pwm_en_out == '0)
      else $error("overvoltage did not drive low");
   a_ov_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ov_seen_q && enabled |=> state_q == ST_LATCH)
      else $error("overvoltage latch lost");
   a_ov_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !vid_valid_q && $past(!vid_valid_q) |-> overvoltage_guard == DAC_OV_FIXED)
      else $error("wrong fixed trip");
   a_oc_hiccup: assert property (@(posedge sys_clk) disable iff (sys_rst)
      iavg_s && enabled && !ov_s && !ov_seen_q && state_q == ST_RUN
      |=> state_q == ST_HICCUP ##1 !driver_enable_out)
      else $error("averaged trip missed");
   a_ready_low_uv: assert property (@(posedge sys_clk) disable iff (sys_rst)
      uv_s |=> regulator_ready_out_oe)
      else $error("ready high under undervoltage");
   c_reach_run: cover property (@(posedge sys_clk) state_q == ST_RUN);
   c_hiccup: cover property (@(posedge sys_clk) state_q == ST_HICCUP);
   c_ov_latch: cover property (@(posedge sys_clk) state_q == ST_LATCH);
   c_ready: cover property (@(posedge sys_clk) !regulator_ready_out_oe);
endmodule : vrs_sequencer

// *** dv/vrs_drv_model.sv ***
// Behavioural gate-driver stage and output rail facing the sequencer.
// Assumes one clock; the bench raises surge_in while the rail overshoots.
`timescale 1ns/10ps
module vrs_drv_model #(
   parameter int unsigned PHASES = 4,
   parameter int unsigned DISCHARGE = 12
) (
   // Clock
   input wire logic sys_clk,
   // Controller side
   input wire logic [PHASES-1:0] pwm_en,
   input wire logic [PHASES-1:0] pwm_oe,
   input wire logic drv_en,
   // Rail side
   input wire logic surge_in,
   output logic diff_low
);
   // ==========================================
   // Rail state
   int unsigned drain_q;
   logic low_side;
   // Lower switches conduct only with every pin driven low and the driver enabled
   assign low_side = drv_en && (&pwm_oe) && !(|pwm_en);
   // Rail starts discharged at power-up
   initial begin
      drain_q = 0;
      diff_low = 1'b1;
   end
   // Rail drains slowly, never at once: a slow discharge exposes early high-Z
   always @(posedge sys_clk) begin
      if (surge_in || (drv_en && |(pwm_en & pwm_oe))) begin
         drain_q <= 0;
         diff_low <= 1'b0;
      end else if (low_side) begin
         drain_q <= drain_q + 1;
         if (drain_q >= DISCHARGE) begin
            diff_low <= 1'b1;
         end
      end
   end
endmodule : vrs_drv_model

// *** dv/tb_vr_startup_fault_sequencer.sv ***
// Self-checking bench for the start-up and protection sequencer.
// Assumes shortened delay parameters and a behavioural driver stage.
`timescale 1ns/10ps
module tb_vr_startup_fault_sequencer;
   import vrs_pkg::*;
   // ==========================================
   // Settings and signals
   localparam int unsigned PH = 4;
   localparam int unsigned T_INIT = 20;
   localparam int unsigned T_HIC = 16;
   localparam int unsigned SW = 4; // Cycles per switching and soft-start tick
   typedef struct packed {int kind; logic [8:0] val;} vrs_note_type;
   logic sys_clk, sys_rst, por_good_in, power_rail_enable_in, term_rail_enable_in;
   logic under_trip_in, under_recover_in, over_trip_in, diff_low, avg_over;
   logic [PH-1:0] ch_over, pwm_en_out, pwm_oe_out;
   logic switch_tick_in, ss_tick_in, vid_off_in, driver_enable_out, rdy_o, rdy_oe;
   logic [7:0] voltage_id_code;
   logic [8:0] vid_target_in, dac_code_out, overvoltage_guard, target, d0;
   vrs_note_type exp_q[$];
   int err_count = 0;
   int samples_checked = 0;
   int seed = 83;
   vrs_sequencer #(.PHASES(PH), .INIT_DELAY(T_INIT), .BOOT_HOLD(10), .READY_DELAY(5),
      .HICCUP(T_HIC)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .por_good_in(por_good_in), .power_rail_enable_in(power_rail_enable_in),
      .term_rail_enable_in(term_rail_enable_in), .under_trip_in(under_trip_in),
      .under_recover_in(under_recover_in), .over_trip_in(over_trip_in),
      .diff_output_sense_low_in(diff_low), .averaged_channel_current_over_in(avg_over),
      .channel_current_over_in(ch_over), .switch_tick_in(switch_tick_in),
      .ss_tick_in(ss_tick_in), .voltage_id_code(voltage_id_code), .vid_off_in(vid_off_in),
      .vid_target_in(vid_target_in), .dac_code_out(dac_code_out),
      .overvoltage_guard(overvoltage_guard), .pwm_en_out(pwm_en_out),
      .pwm_oe_out(pwm_oe_out), .driver_enable_out(driver_enable_out),
      .regulator_ready_out_o(rdy_o), .regulator_ready_out_oe(rdy_oe));
   vrs_drv_model #(.PHASES(PH), .DISCHARGE(12)) drv_u (.sys_clk(sys_clk),
      .pwm_en(pwm_en_out), .pwm_oe(pwm_oe_out), .drv_en(driver_enable_out),
      .surge_in(over_trip_in), .diff_low(diff_low));
   // ==========================================
   // Clock and free-running timebases
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      switch_tick_in = 1'b0;
      ss_tick_in = 1'b0;
      forever begin
         repeat (SW - 1) @(posedge sys_clk);
         #2 {switch_tick_in, ss_tick_in} = 2'b11;
         @(posedge sys_clk);
         #2 {switch_tick_in, ss_tick_in} = 2'b00;
      end
   end
   // ==========================================
   // Helpers: kinds are 0 dac, 1 guard, 2 pin drive, 3 modulators, 4 driver, 5 ready pull,
   // 6 ready drive level
   function automatic logic [8:0] get_obs(input int kind);
      case (kind)
         0: get_obs = dac_code_out;
         1: get_obs = overvoltage_guard;
         2: get_obs = {{(9-PH){1'b0}}, pwm_oe_out};
         3: get_obs = {{(9-PH){1'b0}}, pwm_en_out};
         4: get_obs = {8'h00, driver_enable_out};
         5: get_obs = {8'h00, rdy_oe};
         default: get_obs = {8'h00, rdy_o};
      endcase
   endfunction : get_obs
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic note(input int kind, input logic [8:0] val);
      vrs_note_type e;
      e.kind = kind;
      e.val = val;
      exp_q.push_back(e);
   endtask : note
   // Bounded wait; a miss is a mismatch, then the state is noted anyway
   task automatic wait_for(input int kind, input logic [8:0] val, input int limit);
      int i;
      for (i = 0; i < limit && get_obs(kind) !== val; i++) tick(1);
      note(kind, val);
   endtask : wait_for
   task automatic compare_code(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t code got %h exp %h", $time, got, exp);
      end
   endtask : compare_code
   task automatic compare_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t flag got %h exp %h", $time, got, exp);
      end
   endtask : compare_flag
   // Watcher takes each note off the queue while the outputs are settled
   always @(negedge sys_clk) begin
      while (exp_q.size() > 0) begin
         vrs_note_type e;
         e = exp_q.pop_front();
         if (e.kind >= 4) compare_flag(get_obs(e.kind) != 9'h000, e.val[0]);
         else compare_code(get_obs(e.kind), e.val);
      end
   end
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      #(20 * 40000);
      err_count++;
      print_verdict();
   end
   // Align just after a switching tick has been presented
   task automatic align_tick;
      tick(1);
      while (switch_tick_in !== 1'b1) tick(1);
   endtask : align_tick
   // ==========================================
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {por_good_in, power_rail_enable_in, term_rail_enable_in} = 3'b000;
      {under_trip_in, under_recover_in, over_trip_in, avg_over, vid_off_in} = 5'b00000;
      ch_over = '0;
      voltage_id_code = 8'h00;
      target = 9'h0B0 + 9'(($random(seed) & 32'h3F) + 1);
      vid_target_in = target;
      tick(8);
      sys_rst = 1'b0;
      note(0, 9'h000);
      note(1, DAC_OV_FIXED);
      note(2, 9'h000);
      note(5, 9'h001);
      tick(30);
      note(4, 9'h000);
      por_good_in = 1'b1;
      power_rail_enable_in = 1'b1;
      tick(30);
      note(4, 9'h000);
      term_rail_enable_in = 1'b1;
      voltage_id_code = 8'($random(seed));
      tick(T_INIT / 2);
      note(0, 9'h000);
      note(4, 9'h000);
      wait_for(4, 9'h001, T_INIT + 10);
      note(1, DAC_OV_FIXED);
      d0 = dac_code_out;
      tick(10 * SW);
      note(0, d0 + 9'h00A);
      wait_for(0, DAC_BOOT, 900);
      under_recover_in = 1'b1;
      wait_for(0, target, 600);
      note(1, target + DAC_OV_MARGIN);
      wait_for(5, 9'h000, 30);
      note(6, 9'h000);
      // Undervoltage drops ready, recovery level releases it
      under_recover_in = 1'b0;
      under_trip_in = 1'b1;
      wait_for(5, 9'h001, 6);
      under_trip_in = 1'b0;
      tick(10);
      note(5, 9'h001);
      under_recover_in = 1'b1;
      wait_for(5, 9'h000, 6);
      // Averaged overcurrent trips at once, then hiccup and retry
      avg_over = 1'b1;
      wait_for(4, 9'h000, 4);
      tick(1);
      note(2, 9'h000);
      avg_over = 1'b0;
      tick((T_HIC - 3) * SW);
      note(2, 9'h000);
      note(4, 9'h000);
      wait_for(4, 9'h001, 4 * SW + T_INIT + 20);
      // Channel overcurrent: seven ticks pass, eight trip
      align_tick();
      ch_over[$unsigned($random(seed)) % PH] = 1'b1;
      tick(7 * SW);
      ch_over = '0;
      tick(3 * SW);
      note(4, 9'h001);
      align_tick();
      ch_over[0] = 1'b1;
      tick(8 * SW);
      ch_over = '0;
      wait_for(4, 9'h000, 8);
      wait_for(5, 9'h000, 3000);
      // Supply loss shuts down; restart meets an OFF code
      por_good_in = 1'b0;
      wait_for(5, 9'h001, 6);
      tick(2);
      note(2, 9'h000);
      note(4, 9'h000);
      vid_off_in = 1'b1;
      tick(4);
      por_good_in = 1'b1;
      wait_for(0, DAC_BOOT, 1000);
      tick(60);
      note(4, 9'h000);
      note(5, 9'h001);
      vid_off_in = 1'b0;
      tick(100);
      note(4, 9'h000);
      term_rail_enable_in = 1'b0;
      tick(6);
      term_rail_enable_in = 1'b1;
      wait_for(5, 9'h000, 2000);
      // Overvoltage: low drive, discharge, high-Z, recurrence, latch
      over_trip_in = 1'b1;
      wait_for(3, 9'h000, 4);
      note(2, {{(9-PH){1'b0}}, {PH{1'b1}}});
      note(4, 9'h001);
      note(5, 9'h001);
      tick(4);
      over_trip_in = 1'b0;
      wait_for(2, 9'h000, 30);
      note(4, 9'h000);
      over_trip_in = 1'b1;
      wait_for(2, {{(9-PH){1'b0}}, {PH{1'b1}}}, 4);
      over_trip_in = 1'b0;
      wait_for(2, 9'h000, 30);
      vid_target_in = target - 9'h004;
      tick(200);
      note(4, 9'h000);
      note(3, 9'h000);
      power_rail_enable_in = 1'b0;
      vid_target_in = target;
      tick(6);
      power_rail_enable_in = 1'b1;
      wait_for(4, 9'h001, T_INIT + 20);
      tick(20);
      print_verdict();
   end
endmodule : tb_vr_startup_fault_sequencer
